/* File: flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] norm_block,
	input  wire logic [5:0]  norm_page,
	input  wire logic [3:0]  norm_word,
	input  wire logic [15:0] norm_wdata,
	input  wire logic        norm_we,
	output logic      [15:0] norm_rdata
);
	logic [15:0] cells [int];
	int          key;
	// unwritten cells give a pattern from the word, page and low six block bits, so a wrong address in those bits never reads right
	always @* begin
		key = int'({norm_block, norm_page, norm_word});
		norm_rdata = cells.exists(key) ? cells[key] : ({norm_block[5:0], norm_page, norm_word} ^ 16'h5a3c);
	end
	always @(posedge ref_clk) begin
		if (norm_we === 1'h1) begin
			cells[int'({norm_block, norm_page, norm_word})] = norm_wdata;
		end
	end
endmodule
`default_nettype wire

/* File: otp_dual_ctrl.sv */
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - erase command aimed at the reserved block is refused with error
// R2 - command 65h enters reserved-block access mode for later array operations
// R3 - only cold, warm, hot or core reset leave access mode
// R4 - host should exit with core reset while an erase is suspended
// R5 - reserved block has 64 pages; pages 0-9 user, 10-63 manufacturer
// R6 - each reserved location programs once; programmed words are not rewritten
// R7 - load in access mode copies reserved page into the chosen buffer
// R8 - reserved-block load ignores the block address value
// R9 - host gives an unlocked block address before reserved program or lock
// R10 - host may write buffer data any time before program command
// R11 - host locks by programming low nibble C into lock word
// R12 - after power-up lock word nibble C sets locked flag, status bit 6
// R13 - program to locked reserved block is skipped and sets error bit
// R14 - locked flag can never be cleared
// R15 - cold reset exits access mode and refreshes the locked flag
// R16 - two data buffers work concurrently except during boot load
// R17 - host reads one buffer while the other loads, never the same
// R18 - host writes one buffer while the other programs, never the same
// R19 - address register write during load or program fails that operation
// R20 - reads of busy selected buffer return toggling bit 6
// R21 - toggle valid from 350 ns after load command until transfer ends
// R22 - reads of other buffers return their stored contents during load
// R23 - after cold reset host polls toggle on boot buffer
// R24 - buffer select and count choose buffer and word span
// R25 - reserved access accepted while an erase is suspended
// R26 - access-mode flag holds across operations until a qualifying reset
// R27 - toggle bit inverts on every host read of the busy buffer
module otp_dual_ctrl
	import otp_dual_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        erase_active,
	input  wire logic        erase_suspended,
	input  wire logic [15:0] norm_rdata,
	output logic      [15:0] norm_block,
	output logic      [5:0]  norm_page,
	output logic      [3:0]  norm_word,
	output logic      [15:0] norm_wdata,
	output logic             norm_we,
	output logic             norm_erase,
	output logic             erase_hurt,
	output logic             busy
);

	function automatic logic buf_hit(input logic [7:0] a);
		buf_hit = (a <= A_BUF_LAST);
	endfunction

	function automatic logic is_load_cmd(input logic [15:0] c);
		is_load_cmd = (c == CMD_LOAD) || (c == CMD_LOAD_SPARE) || (c == CMD_LOAD_ALT);
	endfunction

	engine_t     state;
	logic [7:0]  cnt;
	logic [3:0]  xfer_idx;
	logic [3:0]  last_idx;
	logic [1:0]  op_buf;
	logic [5:0]  op_page;
	logic [15:0] op_block;
	logic        op_otp;
	logic        booting;
	logic [15:0] flash_block_addr;
	logic [5:0]  flash_page_addr;
	logic [1:0]  flash_sector_addr;
	logic [1:0]  buffer_sector_select;
	logic [3:0]  buffer_sector_count;
	logic        otp_mode;
	logic        reserved_block_locked_flag;
	logic        err_flag;
	logic        toggle_status_line;
	logic [3:0]  prog_word;
	logic [15:0] buf_mem [0:BUF_ENTRIES-1];
	logic [15:0] otp_mem [0:OTP_ENTRIES-1];

	logic        cmd_go;
	logic        is_reset;
	logic        erase_blocked;
	logic        cmd_ok;
	logic        loading;
	logic        op_busy;
	logic        addr_touch;
	logic        busy_hit;
	logic        prog_hit;
	logic        prog_refused;
	logic        bad_select;
	logic [15:0] otp_word;
	logic [15:0] buf_word;
	logic        last_xfer;
	logic        lock_seen;

	assign cmd_go        = wr && (addr == A_CMD);
	assign is_reset      = cmd_go && ((wdata == CMD_RST_CORE) || (wdata == CMD_RST_WARM) ||
	                                  (wdata == CMD_RST_HOT) || (wdata == CMD_RST_COLD));
	// a running erase ignores all but resets; a suspended one lets others through
	assign erase_blocked = erase_active && !erase_suspended;
	assign cmd_ok        = cmd_go && !is_reset && (state == ST_IDLE) && !erase_blocked;
	assign loading       = (state == ST_SENSE) || (state == ST_XFER);
	assign op_busy       = loading || (state == ST_PROG);
	assign addr_touch    = wr && ((addr == A_BLOCK) || (addr == A_PAGE) || (addr == A_SECTOR));
	assign busy_hit      = loading && buf_hit(addr) && (addr[5:4] == op_buf);
	assign prog_hit      = (state == ST_PROG) && buf_hit(addr) && (addr[5:4] == op_buf);
	assign bad_select    = (buffer_sector_select == BUF_BAD);
	// R5 manufacturer pages refused
	assign prog_refused  = bad_select || (otp_mode && (reserved_block_locked_flag ||
	                                      (flash_page_addr > USER_LAST_PAGE)));
	assign otp_word      = otp_mem[{op_page, xfer_idx}];
	assign buf_word      = buf_mem[{op_buf, xfer_idx}];
	assign last_xfer     = (xfer_idx == last_idx);
	assign lock_seen     = (otp_mem[LOCK_INDEX][3:0] == LOCK_NIBBLE);
	assign busy          = (state != ST_IDLE);
	assign norm_block    = op_block;
	assign norm_page     = op_page;
	assign norm_word     = norm_we ? prog_word : xfer_idx;

	// operation engine
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= ST_LOCKCHK;
			booting  <= 1'b1;
			cnt      <= 8'h00;
			xfer_idx <= 4'h0;
			last_idx <= 4'h0;
			op_buf   <= BUF_BOOT;
			op_page  <= 6'h00;
			op_block <= 16'h0000;
			op_otp   <= 1'b0;
		end else if (is_reset && (wdata == CMD_RST_COLD)) begin
			// R15 cold reset rechecks lock
			state   <= ST_LOCKCHK;
			booting <= 1'b1;
		end else begin
			unique case (state)
				ST_LOCKCHK: begin
					// R16 boot load first
					op_buf   <= BUF_BOOT;
					op_otp   <= 1'b0;
					op_block <= 16'h0000;
					op_page  <= 6'h00;
					last_idx <= LAST_WORD;
					cnt      <= 8'h00;
					xfer_idx <= 4'h0;
					state    <= ST_SENSE;
				end
				ST_IDLE: begin
					if (cmd_ok && !bad_select && (is_load_cmd(wdata) ||
					    ((wdata == CMD_PROG) && !prog_refused))) begin
						// R7 R8 source picked by mode, block ignored in access mode
						op_otp   <= otp_mode;
						op_page  <= flash_page_addr;
						op_block <= flash_block_addr;
						// R24 buffer and span
						op_buf   <= buffer_sector_select;
						last_idx <= buffer_sector_count;
						cnt      <= 8'h00;
						xfer_idx <= 4'h0;
						state    <= is_load_cmd(wdata) ? ST_SENSE : ST_PROG;
					end
				end
				ST_SENSE: begin
					// R19 R21 abort, else full sense time
					if (addr_touch) begin
						state   <= ST_IDLE;
						booting <= 1'b0;
					end else if (cnt == SENSE_LAST) begin
						state <= ST_XFER;
					end else begin
						cnt <= cnt + 8'h01;
					end
				end
				ST_XFER, ST_PROG: begin
					if (addr_touch || last_xfer) begin
						state   <= ST_IDLE;
						booting <= 1'b0;
					end else begin
						xfer_idx <= xfer_idx + 4'h1;
					end
				end
			endcase
		end
	end

	// host address registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_block_addr     <= 16'h0000;
			flash_page_addr      <= 6'h00;
			flash_sector_addr    <= 2'd0;
			buffer_sector_select <= 2'd1;
			buffer_sector_count  <= LAST_WORD;
		end else if (wr) begin
			if (addr == A_BLOCK)
				flash_block_addr <= wdata;
			if (addr == A_PAGE)
				flash_page_addr <= wdata[5:0];
			if (addr == A_SECTOR)
				flash_sector_addr <= wdata[1:0];
			if (addr == A_BUFSEL) begin
				buffer_sector_select <= wdata[1:0];
				buffer_sector_count  <= wdata[11:8];
			end
		end
	end

	// R26 access mode flag, held until reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			otp_mode <= 1'b0;
		end else if (is_reset) begin
			// R3 qualifying resets exit
			otp_mode <= 1'b0;
		end else if (cmd_ok && (wdata == CMD_OTP)) begin
			// R2 R25 entry, also under suspended erase
			otp_mode <= 1'b1;
		end
	end

	// lock flag: only power-up reset clears it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reserved_block_locked_flag <= 1'b0;
		end else if ((state == ST_LOCKCHK) && lock_seen) begin
			// R12 R14 lock word sets, nothing clears
			reserved_block_locked_flag <= 1'b1;
		end
	end

	// error flag: a new command clears it, any failure in that cycle wins
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_flag <= 1'b0;
		end else if ((cmd_ok && (wdata == CMD_PROG) && prog_refused) ||
		             (cmd_ok && (wdata == CMD_ERASE) && otp_mode) ||
		             (cmd_ok && is_load_cmd(wdata) && bad_select) ||
		             (op_busy && addr_touch) ||
		             ((state == ST_PROG) && op_otp && (otp_word != ERASED_WORD))) begin
			// R1 R13 R6 R19 failures
			err_flag <= 1'b1;
		end else if (cmd_ok) begin
			err_flag <= 1'b0;
		end
	end

	// erase and hazard strobes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			norm_erase <= 1'b0;
			erase_hurt <= 1'b0;
		end else begin
			// R1 no erase in access mode
			norm_erase <= cmd_ok && (wdata == CMD_ERASE) && !otp_mode;
			// R4 only the core reset spares a suspended erase
			erase_hurt <= is_reset && (wdata != CMD_RST_CORE) && erase_suspended;
		end
	end

	// array program port
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			norm_we    <= 1'b0;
			norm_wdata <= 16'h0000;
			prog_word  <= 4'h0;
		end else begin
			norm_we    <= (state == ST_PROG) && !op_otp && !addr_touch;
			norm_wdata <= buf_word;
			prog_word  <= xfer_idx;
		end
	end

	// reserved block storage; erased at power-up, never erased afterwards
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < OTP_ENTRIES; i++)
				otp_mem[i] <= ERASED_WORD;
		end else if ((state == ST_PROG) && op_otp && !addr_touch && (otp_word == ERASED_WORD)) begin
			// R6 only erased words take data
			otp_mem[{op_page, xfer_idx}] <= buf_word;
		end
	end

	// on-chip buffers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < BUF_ENTRIES; i++)
				buf_mem[i] <= 16'h0000;
		end else begin
			// R10 R17 R18 host writes, except to the busy buffer or during boot
			if (wr && buf_hit(addr) && !busy_hit && !prog_hit && !booting)
				buf_mem[addr[5:0]] <= wdata;
			// R7 transfer into the selected buffer
			if ((state == ST_XFER) && !addr_touch)
				buf_mem[{op_buf, xfer_idx}] <= op_otp ? otp_word : norm_rdata;
		end
	end

	// R27 toggle flips per busy read
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			toggle_status_line <= 1'b0;
		end else if (rd && busy_hit) begin
			toggle_status_line <= ~toggle_status_line;
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 16'h0000;
		end else if (!rd) begin
			rdata <= 16'h0000;
		end else if (buf_hit(addr)) begin
			// R20 R22 R23 busy buffer shows status, others show data
			if (busy_hit)
				rdata <= 16'(toggle_status_line) << TOGGLE_BIT;
			else
				rdata <= buf_mem[addr[5:0]];
		end else begin
			unique case (addr)
				A_BLOCK:  rdata <= flash_block_addr;
				A_PAGE:   rdata <= {10'h000, flash_page_addr};
				A_SECTOR: rdata <= {14'h0000, flash_sector_addr};
				A_BUFSEL: rdata <= {4'h0, buffer_sector_count, 6'h00, buffer_sector_select};
				A_STATUS: rdata <= (16'(busy) << ST_BUSY) | (16'(err_flag) << ST_ERR) |
				                   (16'(reserved_block_locked_flag) << ST_LOCKED) |
				                   (16'(otp_mode) << ST_OTP);
				default:  rdata <= 16'h0000;
			endcase
		end
	end

	chk_otp_erase_refused: // R1
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_ok && (wdata == CMD_ERASE) && otp_mode |=> !norm_erase && err_flag)
		else $error("erase reached the reserved block");

	chk_otp_entry: // R2
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_ok && (wdata == CMD_OTP) |=> otp_mode [*1] ##1 (otp_mode || $past(is_reset)))
		else $error("access mode not entered");

	chk_access_exit: // R3
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(otp_mode) |-> $past(is_reset))
		else $error("access mode left without reset");

	chk_user_area: // R5
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == ST_PROG) && op_otp |-> op_page <= USER_LAST_PAGE)
		else $error("manufacturer page programmed");

	chk_write_once: // R6
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == ST_PROG) && op_otp && (otp_word != ERASED_WORD) && !addr_touch
		|=> err_flag && (otp_mem[{op_page, $past(xfer_idx)}] == $past(otp_word)))
		else $error("programmed word overwritten");

	chk_locked_prog: // R13
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_ok && (wdata == CMD_PROG) && otp_mode && reserved_block_locked_flag
		|=> err_flag && (state == ST_IDLE))
		else $error("locked block accepted a program");

	chk_lock_sticky: // R14
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		reserved_block_locked_flag |=> reserved_block_locked_flag)
		else $error("lock flag cleared");

	chk_toggle_read: // R20
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd && busy_hit |=> (rdata[TOGGLE_BIT] == $past(toggle_status_line)) &&
		(toggle_status_line != $past(toggle_status_line)))
		else $error("toggle bit did not flip");

	chk_sense_span: // R21
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == ST_XFER) && ($past(state) == ST_SENSE) |-> $past(cnt) == SENSE_LAST)
		else $error("load sensing cut short");

	chk_addr_abort: // R19
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		op_busy && addr_touch && !is_reset |=> (state == ST_IDLE) && err_flag)
		else $error("address change did not fail operation");

	chk_mode_holds: // R26
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		otp_mode && !is_reset |=> otp_mode)
		else $error("access mode dropped");

endmodule

`default_nettype wire

/* File: otp_dual_pkg.sv */
package otp_dual_pkg;

	// geometry of a page and of the reserved block
	localparam int          WORDS          = 16;
	localparam int          BUF_ENTRIES    = 48;
	localparam int          OTP_ENTRIES    = 1024;
	localparam logic [3:0]  LAST_WORD      = 4'hf;
	localparam logic [5:0]  USER_LAST_PAGE = 6'h09;
	localparam logic [9:0]  LOCK_INDEX     = 10'h007;
	localparam logic [3:0]  LOCK_NIBBLE    = 4'hc;
	localparam logic [15:0] ERASED_WORD    = 16'hffff;

	// command codes
	localparam logic [15:0] CMD_LOAD       = 16'h0000;
	localparam logic [15:0] CMD_LOAD_SPARE = 16'h0013;
	localparam logic [15:0] CMD_LOAD_ALT   = 16'h00e0;
	localparam logic [15:0] CMD_PROG       = 16'h0080;
	localparam logic [15:0] CMD_ERASE      = 16'h0094;
	localparam logic [15:0] CMD_OTP        = 16'h0065;
	localparam logic [15:0] CMD_RST_CORE   = 16'h00f0;
	localparam logic [15:0] CMD_RST_WARM   = 16'h00f1;
	localparam logic [15:0] CMD_RST_HOT    = 16'h00f3;
	localparam logic [15:0] CMD_RST_COLD   = 16'h00f5;

	// register port word addresses
	localparam logic [7:0]  A_BUF_LAST     = 8'h2f;
	localparam logic [7:0]  A_BLOCK        = 8'h40;
	localparam logic [7:0]  A_PAGE         = 8'h41;
	localparam logic [7:0]  A_SECTOR       = 8'h42;
	localparam logic [7:0]  A_BUFSEL       = 8'h43;
	localparam logic [7:0]  A_CMD          = 8'h44;
	localparam logic [7:0]  A_STATUS       = 8'h45;

	// status bit positions
	localparam int          ST_BUSY        = 15;
	localparam int          ST_ERR         = 10;
	localparam int          ST_LOCKED      = 6;
	localparam int          ST_OTP         = 0;
	localparam int          TOGGLE_BIT     = 6;

	// buffer numbers
	localparam logic [1:0]  BUF_BOOT       = 2'd0;
	localparam logic [1:0]  BUF_BAD        = 2'd3;

	// timing
	localparam int          CLK_PERIOD_NS  = 25;
	localparam int          TOGGLE_NS      = 350;
	localparam int          TOGGLE_CYC     = (TOGGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SENSE_EXTRA    = 6;
	localparam logic [7:0]  SENSE_LAST     = 8'(TOGGLE_CYC + SENSE_EXTRA - 1);

	typedef enum logic [2:0] {
		ST_LOCKCHK,
		ST_IDLE,
		ST_SENSE,
		ST_XFER,
		ST_PROG
	} engine_t;

endpackage

/* File: test_otp_access_dual_buffer_status.sv */
`timescale 1ns/1ps
`default_nettype none
module test_otp_access_dual_buffer_status;
	import otp_dual_pkg::*;
	logic        ref_clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0;
	logic        erase_active = 1'h0, erase_suspended = 1'h0;
	logic        norm_we, norm_erase, erase_hurt, busy;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, norm_rdata, norm_block, norm_wdata, v, v1, v2, blk;
	logic [5:0]  norm_page, pg;
	logic [3:0]  norm_word;
	logic [1:0]  sel;
	logic [15:0] shadow [48];
	logic [31:0] seed = 32'h00010842;
	int          mismatches = 0, num_checks = 0, cycles = 0, we_cnt = 0, er_cnt = 0, hurt_cnt = 0, n;

	otp_dual_ctrl otp_dual_ctrl_inst (.ref_clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .erase_active,
		.erase_suspended, .norm_rdata, .norm_block, .norm_page, .norm_word, .norm_wdata, .norm_we,
		.norm_erase, .erase_hurt, .busy);
	flash_array_model flash_array_model_inst (.ref_clk, .norm_block, .norm_page, .norm_word, .norm_wdata,
		.norm_we, .norm_rdata);

	always #12.5 ref_clk = ~ref_clk;

	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	function automatic logic [15:0] pat(input logic [15:0] b, input logic [5:0] p, input int w);
		return {b[5:0], p, 4'(w)} ^ 16'h5a3c;
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		rd <= 1'h1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'h0;
		#1;
		d = rdata;
		@(posedge ref_clk);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		#1;
		while (busy !== 1'h0 && k < 200) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		if (k == 200) begin
			mismatches++;
			$display("ERROR %0t busy stuck", $time);
		end
		// the last array strobe trails busy by one cycle; also realigns the bus to an edge
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic st(input logic [15:0] mask, input logic [15:0] exp);
		rd_reg(A_STATUS, v);
		chk_word(v & mask, exp);
	endtask
	task automatic op(input logic [1:0] s, input logic [3:0] c, input logic [15:0] b, input logic [5:0] p,
			input logic [15:0] cmd);
		wr_reg(A_BLOCK, b);
		wr_reg(A_PAGE, {10'h000, p});
		wr_reg(A_BUFSEL, {4'h0, c, 6'h00, s});
		wr_reg(A_CMD, cmd);
	endtask
	task automatic fill(input int s);
		for (int w = 0; w < 16; w++) begin
			shadow[s * 16 + w] = rnd();
			wr_reg(8'(s * 16 + w), shadow[s * 16 + w]);
		end
	endtask
	task automatic chk_rng(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			rd_reg(8'(i), v);
			chk_word(v, shadow[i]);
		end
	endtask
	task automatic cp(input int d, input int s);
		for (int w = 0; w < 16; w++) shadow[d * 16 + w] = shadow[s * 16 + w];
	endtask

	// counts pulses of the array side and cuts a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (norm_we === 1'h1) we_cnt++;
		if (norm_erase === 1'h1) er_cnt++;
		if (erase_hurt === 1'h1) hurt_cnt++;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR %0t timeout", $time);
			close_out();
		end
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (16) @(posedge ref_clk);
		rd_reg(8'h00, v1);
		rd_reg(8'h00, v2);
		chk_bit(v1[6] ^ v2[6], 1'h1);
		chk_word(v2 & 16'hffbf, 16'h0000);
		wait_idle();
		for (int i = 0; i < 48; i++) shadow[i] = i < 16 ? pat(16'h0000, 6'h00, i) : 16'h0000;
		chk_rng(0, 47);
		st(16'h8441, 16'h0000);
		wr_reg(A_SECTOR, 16'h0002);
		rd_reg(A_SECTOR, v);
		chk_word(v, 16'h0002);
		// each load code once, alternating buffers, last one with a short span
		for (int i = 0; i < 3; i++) begin
			sel = 2'(1 + i % 2);
			blk = rnd();
			pg = 6'(rnd());
			op(sel, i == 2 ? 4'h7 : 4'hf, blk, pg, i == 0 ? CMD_LOAD : i == 1 ? CMD_LOAD_SPARE : CMD_LOAD_ALT);
			repeat (13) @(posedge ref_clk);
			rd_reg(8'(sel * 16 + 3), v1);
			rd_reg(8'(sel * 16 + 3), v2);
			chk_bit(v1[6] ^ v2[6], 1'h1);
			chk_word(v1 & 16'hffbf, 16'h0000);
			rd_reg(8'((3 - sel) * 16 + 5), v);
			chk_word(v, shadow[(3 - sel) * 16 + 5]);
			wait_idle();
			for (int w = 0; w <= (i == 2 ? 7 : 15); w++) shadow[sel * 16 + w] = pat(blk, pg, w);
			chk_rng(16, 47);
		end
		rd_reg(A_BUFSEL, v);
		chk_word(v, 16'h0701);
		fill(2);
		blk = rnd() | 16'h0001;
		pg = 6'(rnd());
		n = we_cnt;
		op(2'h2, 4'hf, blk, pg, CMD_PROG);
		wr_reg(8'h20, ~shadow[32]);
		shadow[16] = rnd();
		wr_reg(8'h10, shadow[16]);
		wait_idle();
		chk_word(16'(we_cnt - n), 16'h0010);
		op(2'h1, 4'hf, blk, pg, CMD_LOAD);
		wait_idle();
		cp(1, 2);
		chk_rng(16, 47);
		// page register touched mid-load
		op(2'h1, 4'hf, blk ^ 16'h0002, pg, CMD_LOAD);
		wr_reg(A_PAGE, 16'h0001);
		wait_idle();
		st(16'h8400, 16'h0400);
		n = er_cnt;
		wr_reg(A_CMD, CMD_ERASE);
		repeat (2) @(posedge ref_clk);
		chk_word(16'(er_cnt - n), 16'h0001);
		wr_reg(A_CMD, CMD_OTP);
		st(16'h0001, 16'h0001);
		op(2'h1, 4'hf, rnd(), 6'h00, CMD_LOAD);
		wait_idle();
		for (int w = 0; w < 16; w++) shadow[16 + w] = ERASED_WORD;
		chk_rng(16, 31);
		fill(2);
		shadow[39] = {shadow[39][15:4], LOCK_NIBBLE};
		wr_reg(8'h27, shadow[39]);
		n = we_cnt;
		op(2'h2, 4'hf, rnd() | 16'h0001, 6'h00, CMD_PROG);
		wait_idle();
		st(16'h0441, 16'h0001);
		chk_word(16'(we_cnt - n), 16'h0000);
		op(2'h1, 4'hf, 16'h0000, 6'h00, CMD_LOAD);
		wait_idle();
		cp(1, 2);
		chk_rng(16, 31);
		fill(2);
		op(2'h2, 4'hf, 16'h0001, 6'h00, CMD_PROG);
		wait_idle();
		st(16'h0400, 16'h0400);
		op(2'h1, 4'hf, 16'h0000, 6'h00, CMD_LOAD);
		wait_idle();
		chk_rng(16, 31);
		op(2'h2, 4'hf, 16'h0001, 6'h0a, CMD_PROG);
		wait_idle();
		st(16'h0400, 16'h0400);
		n = er_cnt;
		wr_reg(A_CMD, CMD_ERASE);
		repeat (2) @(posedge ref_clk);
		chk_word(16'(er_cnt - n), 16'h0000);
		wr_reg(A_CMD, CMD_RST_CORE);
		st(16'h0001, 16'h0000);
		wr_reg(A_CMD, CMD_RST_COLD);
		wait_idle();
		st(16'h0041, 16'h0040);
		wr_reg(A_CMD, CMD_OTP);
		op(2'h2, 4'hf, 16'h0001, 6'h01, CMD_PROG);
		wait_idle();
		st(16'h0440, 16'h0440);
		op(2'h1, 4'hf, 16'h0000, 6'h01, CMD_LOAD);
		wait_idle();
		for (int w = 0; w < 16; w++) shadow[16 + w] = ERASED_WORD;
		chk_rng(0, 31);
		wr_reg(A_CMD, CMD_RST_CORE);
		st(16'h0041, 16'h0040);
		// a running erase blocks commands until suspended
		erase_active <= 1'h1;
		wr_reg(A_CMD, CMD_OTP);
		st(16'h0001, 16'h0000);
		erase_suspended <= 1'h1;
		wr_reg(A_CMD, CMD_OTP);
		st(16'h0001, 16'h0001);
		n = hurt_cnt;
		wr_reg(A_CMD, CMD_RST_CORE);
		st(16'h0001, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			wr_reg(A_CMD, CMD_OTP);
			wr_reg(A_CMD, i == 0 ? CMD_RST_WARM : CMD_RST_HOT);
			st(16'h0001, 16'h0000);
		end
		chk_word(16'(hurt_cnt - n), 16'h0002);
		close_out();
	end
endmodule
`default_nettype wire
